// >>> bench/slsm_fsoe_master.sv
// Behavioural model of the safety link master facing the status monitor.
// Assumes it is driven on clk_sys by task calls from the bench.
`timescale 1ns/1ps
module slsm_fsoe_master (
	input  wire logic   clk_sys,
	output logic        conn_reached,
	output logic [15:0] conn_ident_in,
	output logic        fault_valid,
	output logic [7:0]  fault_code_in,
	output logic        proto_valid,
	output logic [7:0]  proto_version_in,
	output logic        wd_period_valid,
	output logic [15:0] wd_period_in,
	output logic        packet_seen
);
	// Idle levels before any traffic
	initial begin
		{conn_reached, fault_valid, proto_valid, wd_period_valid, packet_seen} = 5'h0_0;
		{conn_ident_in, fault_code_in, proto_version_in, wd_period_in} = 48'h0;
	end
	// assign connection ident; zero only when a scenario asks for refusal
	task automatic connect(input logic [15:0] id);
		@(posedge clk_sys); conn_reached <= 1'b1; conn_ident_in <= id;
		@(posedge clk_sys); conn_reached <= 1'b0; conn_ident_in <= ~id; // Released data flips
	endtask
	// Report a link fault code
	task automatic fault(input logic [7:0] c);
		@(posedge clk_sys); fault_valid <= 1'b1; fault_code_in <= c;
		@(posedge clk_sys); fault_valid <= 1'b0; fault_code_in <= ~c;
	endtask
	// Announce the protocol version in use
	task automatic version(input logic [7:0] v);
		@(posedge clk_sys); proto_valid <= 1'b1; proto_version_in <= v;
		@(posedge clk_sys); proto_valid <= 1'b0; proto_version_in <= ~v;
	endtask
	task automatic period(input logic [15:0] p);
		@(posedge clk_sys); wd_period_valid <= 1'b1; wd_period_in <= p;
		@(posedge clk_sys); wd_period_valid <= 1'b0; wd_period_in <= ~p;
	endtask
	// one safety packet restarts the watchdog
	task automatic packet();
		@(posedge clk_sys); packet_seen <= 1'b1;
		@(posedge clk_sys); packet_seen <= 1'b0;
	endtask
endmodule // slsm_fsoe_master

// >>> bench/tb_safety_link_status_monitor.sv
// Self-checking bench for the safety link status monitor over APB.
// Assumes slsm_pkg, slsm_top and the master model are compiled first.
`timescale 1ns/1ps
module tb_safety_link_status_monitor;
	import slsm_pkg::*;
	localparam int CYC = 4; // Short millisecond for simulation
	logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rnd, r;
	logic        brake_state_valid, safety_fault_in, conn_reached, fault_valid, proto_valid;
	logic [1:0]  brake_state_in;
	logic [15:0] conn_ident_in, wd_period_in, id;
	logic [7:0]  fault_code_in, proto_version_in;
	logic        wd_period_valid, packet_seen, safe_state, link_up, e;
	int          fail_count, n_tests, n;

	slsm_top #(.CYC_MS(CYC)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .brake_state_valid(brake_state_valid),
		.brake_state_in(brake_state_in), .safety_fault_in(safety_fault_in),
		.conn_reached(conn_reached), .conn_ident_in(conn_ident_in), .fault_valid(fault_valid),
		.fault_code_in(fault_code_in), .proto_valid(proto_valid),
		.proto_version_in(proto_version_in), .wd_period_valid(wd_period_valid),
		.wd_period_in(wd_period_in), .packet_seen(packet_seen), .safe_state(safe_state),
		.link_up(link_up));
	slsm_fsoe_master i_mst (.clk_sys(clk_sys), .conn_reached(conn_reached),
		.conn_ident_in(conn_ident_in), .fault_valid(fault_valid), .fault_code_in(fault_code_in),
		.proto_valid(proto_valid), .proto_version_in(proto_version_in),
		.wd_period_valid(wd_period_valid), .wd_period_in(wd_period_in),
		.packet_seen(packet_seen));

	// Free-running 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected fault status word from link, safe and fault flags
	function automatic logic [31:0] fstat(input logic lk, input logic sf, input logic fl);
		return {29'h0000_0000, lk, sf, fl};
	endfunction
	// Verdict and end of run
	task automatic conclude();
		if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, x, g);
		end
	endtask
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd_v, output logic err);
		@(posedge clk_sys); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_sys); penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd_v = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// Read and compare a register
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] v;
		logic        er;
		apb(1'b0, a, 32'h0000_0000, v, er);
		chk($sformatf("reg_%h", a), x, v);
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		conclude();
	end
	// Main sequence
	initial begin
		{psel, penable, pwrite, brake_state_valid, safety_fault_in} = 5'h0_0;
		{paddr, pwdata, brake_state_in} = 42'h0;
		fail_count = 0; n_tests = 0; rnd = 32'h28e7_0708;
		rst_n = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(OFF_BRAKE_STATE, 32'h0000_0000);
		rd(OFF_APP_SIZE, 32'h0000_0000);
		rd(OFF_COMM_SIZE, 32'h0000_0002);
		rd(OFF_CONN_KIND, 32'h0000_0002);
		rd(OFF_WD_PERIOD, 32'h0000_0064);
		rd(OFF_CONN_IDENT, 32'h0000_0000);
		apb(1'b1, OFF_CONN_KIND, 32'hffff_ffff, r, e);
		rd(OFF_CONN_KIND, 32'h0000_0002);
		apb(1'b0, 8'h40, 32'h0000_0000, r, e);
		chk("unmapped_err", 32'h0000_0001, {31'h0, e});
		chk("unmapped_data", 32'h0000_0000, r);
		// Random brake states and fault level
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			@(posedge clk_sys); brake_state_valid <= 1'b1; brake_state_in <= rnd[1:0];
			safety_fault_in <= rnd[2];
			@(posedge clk_sys); brake_state_valid <= 1'b0; brake_state_in <= ~rnd[1:0];
			rd(OFF_BRAKE_STATE, {30'h0, rnd[1:0]});
			rd(OFF_FAULT_STAT, fstat(1'b0, 1'b0, rnd[2]));
		end
		safety_fault_in <= 1'b0;
		apb(1'b1, OFF_CONTROL, 32'h0000_0001, r, e);
		rd(OFF_APP_SIZE, 32'h0000_0004);
		apb(1'b1, OFF_CONTROL, 32'h0000_0000, r, e);
		rd(OFF_APP_SIZE, 32'h0000_0000);
		// Every fault code in turn
		for (int i = 0; i < 12; i++) begin
			i_mst.fault(i[7:0]);
			if (i < 6) rd(OFF_LAST_FAULT, i);
			else rd(OFF_LAST_FAULT, i);
		end
		rnd = lfsr(rnd);
		i_mst.version(rnd[7:0]);
		rd(OFF_PROTO_VER, {24'h0, rnd[7:0]});
		apb(1'b1, OFF_PROTO_VER, ~rnd, r, e);
		rd(OFF_PROTO_VER, {24'h0, rnd[7:0]});
		i_mst.period(16'h0006);
		rd(OFF_WD_PERIOD, 32'h0000_0064);
		i_mst.period(16'h0007);
		rd(OFF_WD_PERIOD, 32'h0000_0007);
		// Zero ident refused, then a random nonzero one captured
		i_mst.connect(16'h0000);
		rd(OFF_LAST_FAULT, 32'h0000_0003);
		rd(OFF_CONN_IDENT, 32'h0000_0000);
		rnd = lfsr(rnd);
		id = rnd[15:0] | 16'h0001;
		i_mst.connect(id);
		rd(OFF_CONN_IDENT, {16'h0, id});
		rd(OFF_FAULT_STAT, fstat(1'b1, 1'b0, 1'b0));
		chk("link_up_on", 32'h0000_0001, {31'h0, link_up});
		// Packets well inside the period keep the link up, then silence expires it
		repeat (5) begin
			repeat (15) @(posedge clk_sys);
			i_mst.packet();
		end
		chk("safe_early", 32'h0000_0000, {31'h0, safe_state});
		n = 0;
		while (safe_state !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		chk("wd_delay", 32'h0000_0001, {31'h0, (n >= 26 && n <= 34)});
		rd(OFF_LAST_FAULT, 32'h0000_0005);
		rd(OFF_FAULT_STAT, fstat(1'b0, 1'b1, 1'b0));
		chk("link_up_off", 32'h0000_0000, {31'h0, link_up});
		apb(1'b1, OFF_CONTROL, 32'h0000_0002, r, e);
		rd(OFF_LAST_FAULT, 32'h0000_0000);
		rd(OFF_FAULT_STAT, fstat(1'b0, 1'b0, 1'b0));
		// Mid-run reset returns a moving brake state to held
		@(posedge clk_sys); brake_state_valid <= 1'b1; brake_state_in <= 2'b11;
		@(posedge clk_sys); brake_state_valid <= 1'b0;
		rd(OFF_BRAKE_STATE, 32'h0000_0003);
		@(posedge clk_sys); rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(OFF_BRAKE_STATE, 32'h0000_0000);
		rd(OFF_WD_PERIOD, 32'h0000_0064);
		conclude();
	end
endmodule // tb_safety_link_status_monitor

// >>> core/slsm_link_watchdog.sv
// Link watchdog: counts milliseconds between safety packets.
// Assumes packet and link flags come from logic on clk_sys.
`timescale 1ns/1ps
module slsm_link_watchdog
	import slsm_pkg::*;
#(
	parameter int CYC_MS = slsm_pkg::CYC_PER_MS
) (
	clk_sys,
	rst_n,
	wd
);
	input wire logic clk_sys;
	input wire logic rst_n;
	slsm_wd_if.wdog  wd;

	logic [31:0] cyc_q;
	logic [15:0] ms_q;
	logic        exp_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n || !wd.link_active || wd.packet_seen || exp_q) begin
			cyc_q <= 32'h0000_0000;
		end else if (cyc_q == 32'(CYC_MS - 1)) begin
			cyc_q <= 32'h0000_0000;
		end else begin
			cyc_q <= cyc_q + 32'h0000_0001;
		end
	end

	// Expiry after period with no packet
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !wd.link_active || wd.packet_seen || exp_q) begin
			ms_q  <= 16'h0000;
			exp_q <= 1'b0;
		end else if (cyc_q == 32'(CYC_MS - 1)) begin
			ms_q  <= ms_q + 16'h0001;
			exp_q <= (ms_q + 16'h0001) >= wd.wd_period_ms;
		end else begin
			exp_q <= 1'b0;
		end
	end

	assign wd.expired = exp_q; // One-cycle pulse

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_wd_needs_link: assert property (exp_q |-> $past(wd.link_active))
		else $error("watchdog expired without an active link");
	a_wd_packet_quiet: assert property (wd.packet_seen |=> !exp_q)
		else $error("watchdog expired right after a packet");
endmodule // slsm_link_watchdog

// >>> core/slsm_pkg.sv
// Package for the safety link status monitor: offsets, codes, reset values, timing.
// Assumes a 100 MHz system clock and a 32-bit APB register port.
package slsm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_BRAKE_STATE = 8'h00;
	localparam logic [7:0] OFF_FAULT_STAT  = 8'h04;
	localparam logic [7:0] OFF_APP_SIZE    = 8'h08;
	localparam logic [7:0] OFF_COMM_SIZE   = 8'h0C;
	localparam logic [7:0] OFF_CONN_IDENT  = 8'h10;
	localparam logic [7:0] OFF_CONN_KIND   = 8'h14;
	localparam logic [7:0] OFF_LAST_FAULT  = 8'h18;
	localparam logic [7:0] OFF_PROTO_VER   = 8'h1C;
	localparam logic [7:0] OFF_CONTROL     = 8'h20;
	localparam logic [7:0] OFF_WD_PERIOD   = 8'h24;

	// Field positions
	localparam int CTRL_APP_LINK_BIT = 0;  // App settings over link
	localparam int CTRL_LOCAL_RST_BIT = 1; // Write 1: local link reset
	localparam int FAULT_SAFETY_BIT = 0;
	localparam int FAULT_SAFE_STATE_BIT = 1;
	localparam int FAULT_LINK_UP_BIT = 2;

	// Constant values and reset values
	localparam logic [15:0] APP_SIZE_LOCAL = 16'h0000;
	localparam logic [15:0] APP_SIZE_LINK  = 16'h0004;
	localparam logic [15:0] COMM_SIZE_VAL  = 16'h0002;
	localparam logic [15:0] CONN_KIND_SLAVE = 16'h0002;
	localparam logic [15:0] CONN_IDENT_RST = 16'h0000;
	localparam logic [7:0]  PROTO_VER_RST  = 8'h00;
	localparam logic [31:0] CONTROL_RST    = 32'h0000_0000;
	localparam logic [15:0] WD_PERIOD_RST_MS = 16'h0064;
	localparam logic [15:0] WD_PERIOD_MIN_MS = 16'h0007;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_TIME_NS = 1000000;
	localparam int CYC_PER_MS = MS_TIME_NS / CLK_PERIOD_NS;

	// Brake sequencer states
	typedef enum logic [1:0] {
		BRAKE_HELD      = 2'b00,
		BRAKE_LETTING   = 2'b01,
		BRAKE_LET_GO    = 2'b10,
		BRAKE_APPLYING  = 2'b11
	} slsm_brake_t;

	// Link fault codes
	typedef enum logic [7:0] {
		FLT_RESET       = 8'h00,
		FLT_UNEXP_CMD   = 8'h01,
		FLT_UNKNOWN_CMD = 8'h02,
		FLT_BAD_CONN_ID = 8'h03,
		FLT_CRC         = 8'h04,
		FLT_WATCHDOG    = 8'h05,
		FLT_BAD_ADDR    = 8'h06,
		FLT_BAD_DATA    = 8'h07,
		FLT_COMM_LEN    = 8'h08,
		FLT_COMM_DATA   = 8'h09,
		FLT_APP_LEN     = 8'h0A,
		FLT_APP_DATA    = 8'h0B
	} slsm_fault_t;

endpackage

// >>> core/slsm_top.sv
// Safety link status monitor top: APB status registers and link capture.
// Assumes all link and brake inputs come from logic on clk_sys.
`timescale 1ns/1ps
module slsm_top
	import slsm_pkg::*;
#(
	parameter int CYC_MS = slsm_pkg::CYC_PER_MS
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        brake_state_valid,
	input  wire logic [1:0]  brake_state_in,
	input  wire logic        safety_fault_in,
	input  wire logic        conn_reached,
	input  wire logic [15:0] conn_ident_in,
	input  wire logic        fault_valid,
	input  wire logic [7:0]  fault_code_in,
	input  wire logic        proto_valid,
	input  wire logic [7:0]  proto_version_in,
	input  wire logic        wd_period_valid,
	input  wire logic [15:0] wd_period_in,
	input  wire logic        packet_seen,
	output logic             safe_state,
	output logic             link_up
);
	import slsm_pkg::*;

	slsm_brake_t brake_q;
	slsm_fault_t last_fault_q;
	logic        safety_fault_q;
	logic [15:0] conn_ident_q;
	logic [7:0]  proto_q;
	logic [31:0] control_q;
	logic [15:0] wd_period_q;
	logic        link_up_q;
	logic        safe_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        wr_acc;
	logic        local_rst;
	logic [15:0] app_size;

	slsm_wd_if wd_bus ();

	// Register map decode
	function automatic logic addr_mapped(input logic [7:0] a);
		return a inside {OFF_BRAKE_STATE, OFF_FAULT_STAT, OFF_APP_SIZE, OFF_COMM_SIZE,
			OFF_CONN_IDENT, OFF_CONN_KIND, OFF_LAST_FAULT, OFF_PROTO_VER,
			OFF_CONTROL, OFF_WD_PERIOD};
	endfunction

	assign wr_acc    = psel && penable && pwrite && addr_mapped(paddr);
	assign local_rst = wr_acc && (paddr == OFF_CONTROL) && pwdata[CTRL_LOCAL_RST_BIT];
	assign app_size  = control_q[CTRL_APP_LINK_BIT] ? APP_SIZE_LINK : APP_SIZE_LOCAL;

	// Control register, only the source bit is stored
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			control_q <= CONTROL_RST;
		end else if (wr_acc && paddr == OFF_CONTROL) begin
			control_q <= {31'h0000_0000, pwdata[CTRL_APP_LINK_BIT]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			brake_q <= BRAKE_HELD; // Held until the sequencer moves
		end else if (brake_state_valid) begin
			brake_q <= slsm_brake_t'(brake_state_in);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			safety_fault_q <= 1'b0;
		end else begin
			safety_fault_q <= safety_fault_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			proto_q <= PROTO_VER_RST;
		end else if (proto_valid) begin
			proto_q <= proto_version_in;
		end
	end

	// Watchdog period from master; below the minimum is ignored
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wd_period_q <= WD_PERIOD_RST_MS;
		end else if (wd_period_valid && wd_period_in >= WD_PERIOD_MIN_MS) begin
			wd_period_q <= wd_period_in;
		end
	end

	// Connection ident and link state; a valid connect beats a local reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			conn_ident_q <= CONN_IDENT_RST;
			link_up_q    <= 1'b0;
		end else if (wd_bus.expired) begin
			link_up_q <= 1'b0;
		end else if (conn_reached && conn_ident_in != 16'h0000) begin
			conn_ident_q <= conn_ident_in;
			link_up_q    <= 1'b1;
		end else if (local_rst) begin
			link_up_q <= 1'b0;
		end
	end

	// Safe state on expiry, left on a new connection
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			safe_q <= 1'b0;
		end else if (wd_bus.expired) begin
			safe_q <= 1'b1;
		end else if (local_rst || (conn_reached && conn_ident_in != 16'h0000)) begin
			safe_q <= 1'b0;
		end
	end

	// Last fault code; watchdog wins, then zero ident, local reset, events
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			last_fault_q <= FLT_RESET;
		end else if (wd_bus.expired) begin
			last_fault_q <= FLT_WATCHDOG;
		end else if (conn_reached && conn_ident_in == 16'h0000) begin
			last_fault_q <= FLT_BAD_CONN_ID;
		end else if (local_rst) begin
			last_fault_q <= FLT_RESET;
		end else if (fault_valid) begin
			// Codes 6 to 11 pass the same way
			last_fault_q <= slsm_fault_t'(fault_code_in);
		end
	end

	// Interface to the watchdog
	assign wd_bus.wd_period_ms = wd_period_q;
	assign wd_bus.packet_seen  = packet_seen;
	assign wd_bus.link_active  = link_up_q;

	slsm_link_watchdog #(
		.CYC_MS (CYC_MS)
	) u_wdog (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.wd      (wd_bus.wdog)
	);

	// APB read data, latched in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= !addr_mapped(paddr);
			unique case (paddr)
				OFF_BRAKE_STATE: prdata_q <= {30'h0000_0000, brake_q};
				OFF_FAULT_STAT:  prdata_q <= {29'h0000_0000, link_up_q, safe_q, safety_fault_q};
				OFF_APP_SIZE:    prdata_q <= {16'h0000, app_size};
				OFF_COMM_SIZE:   prdata_q <= {16'h0000, COMM_SIZE_VAL};
				OFF_CONN_IDENT:  prdata_q <= {16'h0000, conn_ident_q};
				OFF_CONN_KIND:   prdata_q <= {16'h0000, CONN_KIND_SLAVE};
				OFF_LAST_FAULT:  prdata_q <= {24'h00_0000, last_fault_q};
				OFF_PROTO_VER:   prdata_q <= {24'h00_0000, proto_q};
				OFF_CONTROL:     prdata_q <= control_q;
				OFF_WD_PERIOD:   prdata_q <= {16'h0000, wd_period_q};
				default:         prdata_q <= 32'h0000_0000; // Unmapped
			endcase
		end
	end

	assign prdata     = prdata_q;
	assign pslverr    = pslverr_q && psel && penable;
	assign pready     = 1'b1; // Zero wait states
	assign safe_state = safe_q;
	assign link_up    = link_up_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_setup_read(logic [7:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	a_brake_after_reset: assert property ($rose(rst_n) |-> brake_q == BRAKE_HELD)
		else $error("brake state not held after reset");
	a_brake_update: assert property (brake_state_valid |=> brake_q == $past(brake_state_in))
		else $error("brake state not captured");
	a_fault_flag: assert property (safety_fault_in != safety_fault_q
		|=> safety_fault_q == $past(safety_fault_in))
		else $error("safety fault flag missing");
	a_app_size_link: assert property (s_setup_read(OFF_APP_SIZE) ##0 control_q[CTRL_APP_LINK_BIT]
		|=> prdata_q == 32'h0000_0004)
		else $error("app size not four with link settings");
	a_comm_size: assert property (s_setup_read(OFF_COMM_SIZE) |=> prdata_q == 32'h0000_0002)
		else $error("comm size not two");
	a_conn_capture: assert property (conn_reached && conn_ident_in != 16'h0000
		&& !local_rst && !wd_bus.expired
		|=> conn_ident_q == $past(conn_ident_in) && link_up_q)
		else $error("connection ident not captured");
	a_conn_kind: assert property (s_setup_read(OFF_CONN_KIND) |=> prdata_q == 32'h0000_0002)
		else $error("connection kind not two");
	a_wd_fault: assert property (wd_bus.expired |=> last_fault_q == FLT_WATCHDOG && safe_q)
		else $error("watchdog expiry not recorded");
	a_fault_event: assert property (fault_valid && !wd_bus.expired && !local_rst && !conn_reached
		|=> last_fault_q == $past(fault_code_in))
		else $error("fault code not recorded");
	a_proto_capture: assert property (proto_valid
		|=> proto_q == $past(proto_version_in))
		else $error("protocol version not readable");
endmodule // slsm_top

// >>> core/slsm_wd_if.sv
// Interface between the monitor top and its link watchdog.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface slsm_wd_if;
	logic [15:0] wd_period_ms;
	logic        packet_seen;
	logic        link_active;
	logic        expired;

	modport ctrl (output wd_period_ms, output packet_seen, output link_active, input expired);
	modport wdog (input wd_period_ms, input packet_seen, input link_active, output expired);
endinterface
